// >>> aog_defs.svh
// aog_defs.svh: address map, register indices and step constants for the operand
// address generator; assumes an 8-bit data space core with a 16-bit data address.
`ifndef AOG_DEFS_SVH
`define AOG_DEFS_SVH

// data space regions
`define AOG_IO_BASE 16'h0020
`define AOG_SRAM_BASE 16'h0060
// last i/o address reachable by single-bit operations
`define AOG_BIT_IO_LAST 6'h1f
// low byte index of each pointer pair in the register file
`define AOG_PTR_X_LO 5'h1a
`define AOG_PTR_Y_LO 5'h1c
`define AOG_PTR_Z_LO 5'h1e
// pointer and program counter steps
`define AOG_PTR_STEP 16'h0001
`define AOG_PC_STEP 12'h001
`define AOG_PC_STEP_TWO_WORD 12'h002
// reset values and the single-bit mask seed
`define AOG_RST_BYTE 8'h00
`define AOG_RST_WORD 16'h0000
`define AOG_RST_PC 12'h000
`define AOG_BIT_ONE 8'h01

`endif

// >>> aog_pkg.sv
// aog_pkg.sv: types shared by the operand address generator and its pointer unit;
// assumes an external decoder fills the request struct one instruction at a time.
package aog_pkg;

   typedef enum logic [3:0] {
      AOG_OP_NOP = 4'b0000,
      AOG_OP_REG_PAIR = 4'b0001,
      AOG_OP_IO_LOAD = 4'b0010,
      AOG_OP_IO_STORE = 4'b0011,
      AOG_OP_DATA_LOAD = 4'b0100,
      AOG_OP_DATA_STORE = 4'b0101,
      AOG_OP_CODE_CONST_LOAD = 4'b0110,
      AOG_OP_JUMP_VIA_POINTER = 4'b0111,
      AOG_OP_CALL_VIA_POINTER = 4'b1000,
      AOG_OP_RELATIVE_JUMP = 4'b1001,
      AOG_OP_RELATIVE_CALL = 4'b1010,
      AOG_OP_IO_BIT_SET_OP = 4'b1011,
      AOG_OP_IO_BIT_CLEAR_OP = 4'b1100,
      AOG_OP_SKIP_IF_BIT_SET = 4'b1101,
      AOG_OP_SKIP_IF_BIT_CLEAR = 4'b1110
   } aog_op_t;

   typedef enum logic [2:0] {
      AOG_AM_DIRECT = 3'b000,
      AOG_AM_PLAIN = 3'b001,
      AOG_AM_PREDEC = 3'b010,
      AOG_AM_POSTINC = 3'b011,
      AOG_AM_DISP = 3'b100
   } aog_amode_t;

   typedef enum logic [1:0] {
      AOG_PSEL_X = 2'b00,
      AOG_PSEL_Y = 2'b01,
      AOG_PSEL_Z = 2'b10
   } aog_psel_t;

   typedef enum logic [1:0] {
      AOG_RG_REG = 2'b00,
      AOG_RG_IO = 2'b01,
      AOG_RG_SRAM = 2'b10,
      AOG_RG_NONE = 2'b11
   } aog_region_t;

   typedef enum logic [1:0] {
      AOG_ST_IDLE = 2'b00,
      AOG_ST_ACCESS = 2'b01,
      AOG_ST_RMW = 2'b10
   } aog_state_t;

   typedef struct packed {
      aog_op_t op;
      aog_amode_t amode;
      aog_psel_t psel;
      logic [4:0] dst_reg;
      logic [4:0] source_reg;
      logic [5:0] io_addr;
      logic [2:0] bit_idx;
      logic [5:0] disp;
      logic [15:0] direct_addr;
      logic [11:0] rel_off;
   } aog_req_t;

   typedef struct packed {
      logic jump;
      logic call;
      logic [11:0] target;
      logic [11:0] ret_addr;
   } aog_flow_t;

endpackage : aog_pkg

// >>> aog_ptr_unit.sv
// aog_ptr_unit.sv: combinational operand address and pointer update for one pointer pair;
// assumes the caller writes ptr_next back only when ptr_upd is high.
`timescale 1ns/1ns
`include "aog_defs.svh"

module aog_ptr_unit
   import aog_pkg::*;
#(
   parameter int PW = 16
) (
   input aog_amode_t amode,
   input logic [PW-1:0] ptr_val,
   input logic [5:0] disp,
   output logic [PW-1:0] op_addr,
   output logic [PW-1:0] ptr_next,
   output logic ptr_upd
);

   if (PW != 16) begin : g_bad_width
      $error("aog_ptr_unit: pointer pairs are two bytes wide");
   end

   wire [PW-1:0] ptr_dec;
   wire [PW-1:0] ptr_inc;
   wire [PW-1:0] disp_sum;

   // full 16-bit arithmetic, carry crosses the byte boundary and wraps [R25]
   assign ptr_dec = ptr_val - `AOG_PTR_STEP;
   assign ptr_inc = ptr_val + `AOG_PTR_STEP;
   // unsigned six-bit offset above the base, 0..63 [R4] [R23]
   assign disp_sum = ptr_val + {10'h000, disp};

   // predecrement uses the new value, postincrement the old one [R5] [R6] [R7]
   assign op_addr = (amode == AOG_AM_PREDEC) ? ptr_dec :
                    (amode == AOG_AM_DISP) ? disp_sum : ptr_val;
   assign ptr_next = (amode == AOG_AM_PREDEC) ? ptr_dec : ptr_inc;
   assign ptr_upd = (amode == AOG_AM_PREDEC) || (amode == AOG_AM_POSTINC);

endmodule : aog_ptr_unit

// >>> aog_core.sv
// aog_core.sv: register file, operand address generation, data/io/code access sequencing
// and program flow targets; assumes a decoder offering one request at a time and
// memories and i/o that answer in the same cycle as the registered strobe.
`timescale 1ns/1ns
`include "aog_defs.svh"

// Function
// (R1) two-register ops read source and destination, result written to destination
// (R2) i/o direct takes a six-bit i/o address field plus a register field
// (R3) data direct uses the 16-bit address word of a two-word instruction
// (R4) displacement mode adds six-bit offset to the Y or Z pointer; the code also adds it to X when X is selected
// (R5) plain indirect uses any pointer pair unchanged as address
// (R6) predecrement: decrement pointer, use and keep the decremented value
// (R7) postincrement: use old pointer value, then increment the pointer
// (R8) code constant: Z upper fifteen bits give word, bit 0 picks byte; the code uses only z[12:1] as the word
// (R9) pointer jump and call load the program counter from Z
// (R10) relative jump and call go to pc plus offset plus one
// (R11) core runs directly on the system clock, no division
// (R12) next instruction fetched while the current one executes
// (R13) register read, alu operation and writeback complete in one cycle
// (R14) every internal data memory access takes two clock cycles
// (R15) i/o addresses 0x00..0x3f also appear at data addresses plus 0x20
// (R16) bit set/clear and bit skips only for i/o addresses 0x00..0x1f
// (R17) some i/o flags clear when a one is written to them
// (R18) bit set/clear rewrite the whole register, set flags written back as one
// (R19) software should write reserved bits as zero
// (R20) software must never write reserved i/o addresses
// (R21) data space: registers 0x00-0x1f, i/o 0x20-0x5f, sram from 0x60
// (R22) pointer pairs are registers 26..31 as low/high byte pairs
// (R23) displacement reaches 63 locations above the pointer base
// (R24) program counter is 12 bits, jump targets truncated to it
// (R25) pointer steps are 16-bit with byte carry, wrapping modulo 65536
// (R26) data accesses above sram have no effect, reads return zero
module aog_core
   import aog_pkg::*;
#(
   parameter int SRAM_AW = 9
) (
   input logic clk,
   input logic rst_n,
   input logic req_valid,
   input aog_req_t req,
   output logic req_ready,
   output logic [7:0] alu_a,
   output logic [7:0] alu_b,
   input logic [7:0] alu_result,
   output logic [SRAM_AW-1:0] sram_addr,
   output logic sram_re,
   output logic sram_we,
   output logic [7:0] sram_wdata,
   input logic [7:0] sram_rdata,
   output logic [5:0] io_addr,
   output logic io_re,
   output logic io_we,
   output logic [7:0] io_wdata,
   input logic [7:0] io_rdata,
   output logic [11:0] code_addr,
   output logic code_re,
   output logic code_byte_hi,
   input logic [15:0] code_rdata,
   output logic [11:0] pc,
   output logic [11:0] fetch_addr,
   output aog_flow_t flow,
   output logic skip,
   output logic bit_op_refused
);

   if (SRAM_AW < 1 || SRAM_AW > 15) begin : g_bad_sram
      $error("aog_core: SRAM_AW must lie in 1..15");
   end

   localparam logic [16:0] SRAM_END = {1'b0, `AOG_SRAM_BASE} + (17'h00001 << SRAM_AW);

   logic [7:0] rf [32];
   aog_state_t state;
   aog_req_t acc_req;
   aog_region_t acc_region;
   logic [15:0] acc_addr;
   logic [7:0] wdata;

   // data space split; anything beyond the sram is a dead region [R21] [R26]
   function automatic aog_region_t region_of(input logic [15:0] a);
      if (a < `AOG_IO_BASE) region_of = AOG_RG_REG;
      else if (a < `AOG_SRAM_BASE) region_of = AOG_RG_IO;
      else if ({1'b0, a} < SRAM_END) region_of = AOG_RG_SRAM;
      else region_of = AOG_RG_NONE;
   endfunction : region_of

   // pointer pair low byte index; pairs live in the top six registers [R22]
   function automatic logic [4:0] ptr_lo(input aog_psel_t s);
      case (s)
         AOG_PSEL_X: ptr_lo = `AOG_PTR_X_LO;
         AOG_PSEL_Y: ptr_lo = `AOG_PTR_Y_LO;
         default: ptr_lo = `AOG_PTR_Z_LO;
      endcase
   endfunction : ptr_lo

   wire [4:0] sel_lo = ptr_lo(req.psel);
   wire [4:0] sel_hi = sel_lo | 5'h01;
   wire [15:0] sel_ptr = {rf[sel_hi], rf[sel_lo]};
   wire [15:0] z_ptr = {rf[`AOG_PTR_Z_LO | 5'h01], rf[`AOG_PTR_Z_LO]};

   wire [15:0] ind_addr;
   wire [15:0] ptr_next;
   wire ptr_upd;

   aog_ptr_unit #(.PW(16)) u_ptr (
      .amode(req.amode),
      .ptr_val(sel_ptr),
      .disp(req.disp),
      .op_addr(ind_addr),
      .ptr_next(ptr_next),
      .ptr_upd(ptr_upd)
   );

   // request decode
   wire accept = req_valid && (state == AOG_ST_IDLE);
   wire is_ld = (req.op == AOG_OP_DATA_LOAD) || (req.op == AOG_OP_IO_LOAD);
   wire is_st = (req.op == AOG_OP_DATA_STORE) || (req.op == AOG_OP_IO_STORE);
   wire is_mem = (req.op == AOG_OP_DATA_LOAD) || (req.op == AOG_OP_DATA_STORE);
   wire is_bit = (req.op == AOG_OP_IO_BIT_SET_OP) || (req.op == AOG_OP_IO_BIT_CLEAR_OP) ||
                 (req.op == AOG_OP_SKIP_IF_BIT_SET) || (req.op == AOG_OP_SKIP_IF_BIT_CLEAR);
   wire is_const = (req.op == AOG_OP_CODE_CONST_LOAD);
   wire is_direct = is_mem && (req.amode == AOG_AM_DIRECT);
   // upper half of the i/o map has no bit access [R16]
   wire bit_ok = (req.io_addr <= `AOG_BIT_IO_LAST);
   wire go = accept && (is_ld || is_st || is_const || (is_bit && bit_ok));
   wire ptr_we = accept && is_mem && !is_direct && ptr_upd;

   // direct address from the second instruction word [R3]; i/o field mapped up [R2] [R15]
   wire [15:0] io_dspace = `AOG_IO_BASE + {10'h000, req.io_addr};
   wire [15:0] next_addr = is_direct ? req.direct_addr : is_mem ? ind_addr : io_dspace;
   wire aog_region_t next_region = region_of(next_addr);
   wire [15:0] sram_off = next_addr - `AOG_SRAM_BASE;
   // i/o index from whichever address was formed, data space or i/o field [R15]
   wire [15:0] io_off = next_addr - `AOG_IO_BASE;

   wire next_sram_re = go && is_ld && (next_region == AOG_RG_SRAM);
   wire next_sram_we = go && is_st && (next_region == AOG_RG_SRAM);
   wire next_io_re = go && ((is_ld && next_region == AOG_RG_IO) || is_bit);
   wire next_io_we_req = go && is_st && (next_region == AOG_RG_IO);

   // access cycle decode
   wire in_access = (state == AOG_ST_ACCESS);
   wire acc_ld = (acc_req.op == AOG_OP_DATA_LOAD) || (acc_req.op == AOG_OP_IO_LOAD);
   wire acc_st = (acc_req.op == AOG_OP_DATA_STORE) || (acc_req.op == AOG_OP_IO_STORE);
   wire acc_const = (acc_req.op == AOG_OP_CODE_CONST_LOAD);
   wire acc_rmw = (acc_req.op == AOG_OP_IO_BIT_SET_OP) ||
                  (acc_req.op == AOG_OP_IO_BIT_CLEAR_OP);
   wire acc_skip_op = (acc_req.op == AOG_OP_SKIP_IF_BIT_SET) ||
                      (acc_req.op == AOG_OP_SKIP_IF_BIT_CLEAR);
   wire [7:0] bit_mask = `AOG_BIT_ONE << acc_req.bit_idx;
   // pointer named by the request in flight, not by whatever is offered now
   wire [4:0] acc_lo = ptr_lo(acc_req.psel);
   wire [15:0] acc_ptr = {rf[acc_lo | 5'h01], rf[acc_lo]};
   wire bit_val = |(io_rdata & bit_mask);
   wire skip_hit = in_access && acc_skip_op &&
                   (bit_val == (acc_req.op == AOG_OP_SKIP_IF_BIT_SET));
   // whole register rewritten: a set w1c flag goes back as one and clears [R17] [R18]
   wire [7:0] rmw_val = (acc_req.op == AOG_OP_IO_BIT_SET_OP) ? (io_rdata | bit_mask) :
                        (io_rdata & ~bit_mask);
   // selected byte of the program word [R8]
   wire [7:0] code_byte = code_byte_hi ? code_rdata[15:8] : code_rdata[7:0];
   // dead region reads as zero and nothing is strobed [R26]
   wire [7:0] ld_data = acc_const ? code_byte :
                        (acc_region == AOG_RG_REG) ? rf[acc_addr[4:0]] :
                        (acc_region == AOG_RG_IO) ? io_rdata :
                        (acc_region == AOG_RG_SRAM) ? sram_rdata : `AOG_RST_BYTE;

   // single register file write port
   wire rf_alu_we = accept && (req.op == AOG_OP_REG_PAIR);
   wire rf_acc_we = in_access && (acc_ld || acc_const || (acc_st && acc_region == AOG_RG_REG));
   wire rf_we = rf_alu_we || rf_acc_we;
   wire [4:0] rf_waddr = rf_alu_we ? req.dst_reg : acc_st ? acc_addr[4:0] : acc_req.dst_reg;
   wire [7:0] rf_wdata = rf_alu_we ? alu_result : acc_st ? wdata : ld_data;

   // both operands come straight off the register file [R1] [R13]
   assign alu_a = rf[req.dst_reg];
   assign alu_b = rf[req.source_reg];
   assign req_ready = (state == AOG_ST_IDLE);
   // prefetch runs one word ahead of the executing instruction [R12]
   assign fetch_addr = pc + `AOG_PC_STEP;
   assign sram_wdata = wdata;
   assign io_wdata = wdata;

   // program flow, all targets cut to 12 bits [R24]
   wire [11:0] rel_target = pc + req.rel_off + `AOG_PC_STEP;
   wire is_ptr_flow = (req.op == AOG_OP_JUMP_VIA_POINTER) ||
                      (req.op == AOG_OP_CALL_VIA_POINTER);
   wire is_rel_flow = (req.op == AOG_OP_RELATIVE_JUMP) || (req.op == AOG_OP_RELATIVE_CALL);
   wire is_call = (req.op == AOG_OP_CALL_VIA_POINTER) || (req.op == AOG_OP_RELATIVE_CALL);
   wire [11:0] flow_target = is_ptr_flow ? z_ptr[11:0] : rel_target;   // [R9] [R10]
   wire [11:0] seq_pc = pc + (is_direct ? `AOG_PC_STEP_TWO_WORD : `AOG_PC_STEP);
   wire [11:0] next_pc = !accept ? (skip_hit ? pc + `AOG_PC_STEP : pc) :
                         (is_ptr_flow || is_rel_flow) ? flow_target : seq_pc;

   aog_state_t next_state;
   assign next_state = (state == AOG_ST_IDLE) ? (go ? AOG_ST_ACCESS : AOG_ST_IDLE) :
                       (state == AOG_ST_ACCESS && acc_rmw) ? AOG_ST_RMW : AOG_ST_IDLE;

   // core state runs on clk itself, no prescaler [R11]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= AOG_ST_IDLE;
         acc_req <= '0;
         acc_region <= AOG_RG_REG;
         acc_addr <= `AOG_RST_WORD;
      end else begin
         state <= next_state;   // two-cycle data access [R14]
         if (accept) begin
            acc_req <= req;
            acc_region <= next_region;
            acc_addr <= next_addr;
         end
      end
   end

   // strobes are registered so the memory sees them in the second cycle [R14]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sram_re <= 1'b0;
         sram_we <= 1'b0;
         sram_addr <= '0;
         io_re <= 1'b0;
         io_we <= 1'b0;
         io_addr <= 6'h00;
      end else begin
         sram_re <= next_sram_re;
         sram_we <= next_sram_we;
         if (go) sram_addr <= sram_off[SRAM_AW-1:0];
         io_re <= next_io_re;
         io_we <= next_io_we_req || (in_access && acc_rmw);   // [R18]
         if (go) io_addr <= io_off[5:0];   // [R15]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdata <= `AOG_RST_BYTE;
         code_re <= 1'b0;
         code_addr <= `AOG_RST_PC;
         code_byte_hi <= 1'b0;
      end else begin
         if (accept) wdata <= rf[req.source_reg];
         else if (in_access && acc_rmw) wdata <= rmw_val;
         code_re <= go && is_const;
         // word address from z[12:1] within the 4k program space [R8]
         if (go && is_const) begin
            code_addr <= z_ptr[12:1];
            code_byte_hi <= z_ptr[0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc <= `AOG_RST_PC;
         flow <= '0;
         skip <= 1'b0;
         bit_op_refused <= 1'b0;
      end else begin
         pc <= next_pc;   // [R9] [R10] [R24]
         flow.jump <= accept && (is_ptr_flow || is_rel_flow);
         flow.call <= accept && is_call;
         if (accept) begin
            flow.target <= flow_target;
            flow.ret_addr <= pc + `AOG_PC_STEP;
         end
         skip <= skip_hit;   // [R16]
         bit_op_refused <= accept && is_bit && !bit_ok;   // [R16]
      end
   end

   // register file; pointer write-back and data writes never share a cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) rf[i] <= `AOG_RST_BYTE;
      end else begin
         if (rf_we) rf[rf_waddr] <= rf_wdata;   // [R1] [R13]
         if (ptr_we) begin   // [R6] [R7] [R25]
            rf[sel_lo] <= ptr_next[7:0];
            rf[sel_hi] <= ptr_next[15:8];
         end
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reg_pair_wb: assert property (rf_alu_we |=> rf[$past(req.dst_reg)] == $past(alu_result)) // [R1]
      else $error("two-register result not in destination");
   a_alu_one_cycle: assert property (rf_alu_we |-> req_ready ##1 req_ready) // [R13]
      else $error("alu operation did not finish in one cycle");
   a_io_field: assert property (accept && req.op == AOG_OP_IO_LOAD |=> io_re && io_addr == $past(req.io_addr)) // [R2]
      else $error("i/o load address differs from the field");
   a_direct_addr: assert property (accept && is_direct |=> acc_addr == $past(req.direct_addr)) // [R3]
      else $error("direct address not taken from the instruction");
   a_disp_sum: assert property (accept && is_mem && req.amode == AOG_AM_DISP
      |=> acc_addr == $past(sel_ptr) + {10'h000, $past(req.disp)}) // [R4]
      else $error("displacement address wrong");
   a_predec_keep: assert property (accept && is_mem && req.amode == AOG_AM_PREDEC
      |=> acc_addr == $past(sel_ptr) - `AOG_PTR_STEP && acc_ptr == acc_addr) // [R6]
      else $error("predecrement address or pointer wrong");
   a_postinc_old: assert property (accept && is_mem && req.amode == AOG_AM_POSTINC
      |=> acc_addr == $past(sel_ptr) && acc_ptr == acc_addr + `AOG_PTR_STEP) // [R7]
      else $error("postincrement address or pointer wrong");
   a_sram_two_cycle: assert property (next_sram_re |=> sram_re ##1 (!sram_re && req_ready)) // [R14]
      else $error("sram access not two cycles");
   a_bit_range: assert property (accept && is_bit && !bit_ok |=> !io_re && !io_we && bit_op_refused) // [R16]
      else $error("bit operation above 0x1f reached i/o");
   a_rmw_whole: assert property (in_access && acc_req.op == AOG_OP_IO_BIT_SET_OP
      |=> io_we && io_wdata == ($past(io_rdata) | $past(bit_mask))) // [R18]
      else $error("bit set did not rewrite the register");
   a_rel_target: assert property (accept && req.op == AOG_OP_RELATIVE_JUMP
      |=> pc == $past(pc) + $past(req.rel_off) + `AOG_PC_STEP) // [R10]
      else $error("relative target wrong");
   a_ptr_jump: assert property (accept && req.op == AOG_OP_JUMP_VIA_POINTER |=> pc == $past(z_ptr[11:0])) // [R9]
      else $error("pointer jump target wrong");
   a_code_addr: assert property (accept && is_const
      |=> code_re && code_addr == $past(z_ptr[12:1]) && code_byte_hi == $past(z_ptr[0])) // [R8]
      else $error("code constant address wrong");

   c_sram_load: cover property (next_sram_re ##1 sram_re);
   c_bit_set: cover property (in_access && acc_rmw ##1 io_we);
   c_skip: cover property (skip);
   c_call: cover property (flow.call);

endmodule : aog_core

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the operand address generator core
// assumes aog_pkg compiled first; the bench plays decoder, memories and i/o
`timescale 1ns/1ns
module tb_top;
   import aog_pkg::*;
   localparam int AW = 9;
   logic clk, rst_n, req_valid, req_ready, sram_re, sram_we, io_re, io_we;
   logic code_re, code_byte_hi, skip, bit_op_refused;
   logic [7:0] alu_a, alu_b, alu_result, sram_wdata, sram_rdata, io_wdata, io_rdata;
   logic [AW-1:0] sram_addr;
   logic [5:0] io_addr;
   logic [11:0] code_addr, pc, fetch_addr;
   logic [15:0] code_rdata, v;
   aog_req_t req, r;
   aog_flow_t flow;
   int bad_count, samples_checked, n;
   aog_core #(.SRAM_AW(AW)) dut (.clk, .rst_n, .req_valid, .req, .req_ready, .alu_a, .alu_b,
      .alu_result, .sram_addr, .sram_re, .sram_we, .sram_wdata, .sram_rdata, .io_addr, .io_re,
      .io_we, .io_wdata, .io_rdata, .code_addr, .code_re, .code_byte_hi, .code_rdata, .pc,
      .fetch_addr, .flow, .skip, .bit_op_refused);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   function automatic aog_req_t mk(aog_op_t op, aog_amode_t am, aog_psel_t ps, logic [4:0] d);
      aog_req_t q;
      q = '0;
      q.op = op;
      q.amode = am;
      q.psel = ps;
      q.dst_reg = d;
      q.source_reg = d;
      return q;
   endfunction : mk
   // answers go out with the request so they are valid in cycle 1
   task automatic run(input logic [15:0] d);
      @(posedge clk);
      sram_rdata <= d[7:0];
      io_rdata <= d[7:0];
      code_rdata <= d;
      req <= r;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask : run
   task automatic wait_ready;
      n = 1;
      while (req_ready !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_ready
   // reads a register pair through the combinational alu operand taps
   task automatic peek(input logic [4:0] i);
      @(posedge clk);
      req.dst_reg <= i;
      req.source_reg <= i + 5'h01;
      #1;
      v = {alu_b, alu_a};
   endtask : peek
   task automatic ld(input logic [4:0] d, input logic [15:0] a, input logic [7:0] x);
      r = mk(AOG_OP_DATA_LOAD, AOG_AM_DIRECT, AOG_PSEL_X, d);
      r.direct_addr = a;
      run({8'h00, x});
      wait_ready;
   endtask : ld
   task automatic set_ptr(input logic [4:0] lo, input logic [15:0] x);
      ld(lo, 16'h0100, x[7:0]);
      ld(lo + 5'h01, 16'h0100, x[15:8]);
   endtask : set_ptr
   // idx ffff means no sram strobe is expected
   task automatic ptr_ld(input aog_amode_t am, input aog_psel_t ps, input logic [5:0] dp,
      input logic [15:0] idx);
      r = mk(AOG_OP_DATA_LOAD, am, ps, 5'h00);
      r.disp = dp;
      run(16'h005a);
      chk("sram_re", 16'(sram_re), 16'(idx != 16'hffff));
      if (idx != 16'hffff) chk("sram_addr", 16'(sram_addr), idx);
      wait_ready;
   endtask : ptr_ld
   task automatic t_direct;
      ld(5'h04, 16'h0100, 8'h22);
      r.direct_addr = 16'h025f;
      r.dst_reg = 5'h03;
      run(16'h0011);
      chk("sram_re", 16'(sram_re), 16'h0001);
      chk("sram_addr", 16'(sram_addr), 16'h01ff);
      wait_ready;
      chk("sram_cycles", 16'(n), 16'h0002);
      r = mk(AOG_OP_DATA_STORE, AOG_AM_DIRECT, AOG_PSEL_X, 5'h03);
      r.direct_addr = 16'h0100;
      run(16'h0000);
      chk("sram_we", 16'(sram_we), 16'h0001);
      chk("sram_wdata", 16'(sram_wdata), 16'h0011);
      chk("sram_addr", 16'(sram_addr), 16'h00a0);
      wait_ready;
      r.direct_addr = 16'h0260;
      run(16'h0000);
      chk("sram_we", 16'(sram_we), 16'h0000);
      wait_ready;
      r = mk(AOG_OP_IO_LOAD, AOG_AM_DIRECT, AOG_PSEL_X, 5'h05);
      r.io_addr = 6'h3f;
      run(16'h00c3);
      chk("io_re", 16'(io_re), 16'h0001);
      chk("io_addr", 16'(io_addr), 16'h003f);
      wait_ready;
      ld(5'h06, 16'h0025, 8'h00);
      chk("io_addr", 16'(io_addr), 16'h0005);
      r.op = AOG_OP_IO_STORE;
      r.io_addr = 6'h10;   // mapped address, whole byte defined
      r.dst_reg = 5'h05;
      r.source_reg = 5'h05;
      run(16'h0000);
      chk("io_we", 16'(io_we), 16'h0001);
      chk("io_wdata", 16'(io_wdata), 16'h00c3);
      chk("io_addr", 16'(io_addr), 16'h0010);
      wait_ready;
      ld(5'h06, 16'h0003, 8'h00);
      peek(5'h06);
      chk("reg_space", {8'h00, v[7:0]}, 16'h0011);
   endtask : t_direct
   task automatic t_pair;
      r = mk(AOG_OP_REG_PAIR, AOG_AM_DIRECT, AOG_PSEL_X, 5'h03);
      r.source_reg = 5'h04;
      @(posedge clk);
      req <= r;
      req_valid <= 1'b1;
      alu_result <= 8'h99;
      #1;
      chk("alu_a", {8'h00, alu_a}, 16'h0011);
      chk("alu_b", {8'h00, alu_b}, 16'h0022);
      r.dst_reg = 5'h04;
      r.source_reg = 5'h03;
      @(posedge clk);
      req <= r;
      alu_result <= 8'h77;
      #1;
      chk("ready_b2b", 16'(req_ready), 16'h0001);
      chk("alu_b", {8'h00, alu_b}, 16'h0099);
      @(posedge clk);
      req_valid <= 1'b0;
      peek(5'h03);
      chk("pair_wb", v, 16'h7799);
   endtask : t_pair
   task automatic t_ptr;
      set_ptr(5'h1a, 16'h01ff);
      ptr_ld(AOG_AM_POSTINC, AOG_PSEL_X, 6'h00, 16'h019f);
      peek(5'h1a);
      chk("x_inc", v, 16'h0200);
      ptr_ld(AOG_AM_PREDEC, AOG_PSEL_X, 6'h00, 16'h019f);
      peek(5'h1a);
      chk("x_dec", v, 16'h01ff);
      set_ptr(5'h1c, 16'hffff);
      ptr_ld(AOG_AM_POSTINC, AOG_PSEL_Y, 6'h00, 16'hffff);
      peek(5'h1c);
      chk("y_wrap", v, 16'h0000);
      peek(5'h00);
      chk("ld_void", {8'h00, v[7:0]}, 16'h0000);
      set_ptr(5'h1c, 16'h0100);
      ptr_ld(AOG_AM_DISP, AOG_PSEL_Y, 6'h3f, 16'h00df);
      set_ptr(5'h1e, 16'h0061);
      ptr_ld(AOG_AM_PLAIN, AOG_PSEL_Z, 6'h00, 16'h0001);
      ptr_ld(AOG_AM_DISP, AOG_PSEL_Z, 6'h02, 16'h0003);
   endtask : t_ptr
   task automatic t_code;
      r = mk(AOG_OP_CODE_CONST_LOAD, AOG_AM_DIRECT, AOG_PSEL_Z, 5'h07);
      run(16'habcd);
      chk("code_re", 16'(code_re), 16'h0001);
      chk("code_addr", 16'(code_addr), 16'h0030);
      chk("code_hi", 16'(code_byte_hi), 16'h0001);
      wait_ready;
      ld(5'h1e, 16'h0100, 8'h22);
      r = mk(AOG_OP_CODE_CONST_LOAD, AOG_AM_DIRECT, AOG_PSEL_Z, 5'h07);
      run(16'habcd);
      chk("code_addr", 16'(code_addr), 16'h0011);
      chk("code_hi", 16'(code_byte_hi), 16'h0000);
      wait_ready;
      peek(5'h07);
      chk("code_byte", {8'h00, v[7:0]}, 16'h00cd);
   endtask : t_code
   task automatic flow_op(input aog_op_t op, input logic [11:0] k, input logic [11:0] t);
      r = mk(op, AOG_AM_DIRECT, AOG_PSEL_Z, 5'h00);
      r.rel_off = k;
      run(16'h0000);
      chk("pc", 16'(pc), 16'(t));
      chk("jump", 16'(flow.jump), 16'h0001);
      chk("call", 16'(flow.call), 16'(op == AOG_OP_CALL_VIA_POINTER || op == AOG_OP_RELATIVE_CALL));
      chk("target", 16'(flow.target), 16'(t));
      chk("fetch", 16'(fetch_addr), 16'(t + 12'h001));
      wait_ready;
   endtask : flow_op
   task automatic t_flow;
      set_ptr(5'h1e, 16'hf123);
      flow_op(AOG_OP_JUMP_VIA_POINTER, 12'h000, 12'h123);
      flow_op(AOG_OP_CALL_VIA_POINTER, 12'h000, 12'h123);
      chk("ret", 16'(flow.ret_addr), 16'h0124);
      flow_op(AOG_OP_RELATIVE_JUMP, 12'h800, 12'h924);
      flow_op(AOG_OP_RELATIVE_CALL, 12'h7ff, 12'h124);
      chk("ret", 16'(flow.ret_addr), 16'h0925);
   endtask : t_flow
   // w: expected write-back for set/clear, expected skip pulse for tests
   task automatic bit_op(input aog_op_t op, input logic [5:0] a, input logic [2:0] b,
      input logic [7:0] d, input logic [7:0] w);
      r = mk(op, AOG_AM_DIRECT, AOG_PSEL_X, 5'h00);
      r.io_addr = a;
      r.bit_idx = b;
      run({8'h00, d});
      chk("refused", 16'(bit_op_refused), 16'(a > 6'h1f));
      chk("io_re", 16'(io_re), 16'(a <= 6'h1f));
      if (a <= 6'h1f) chk("io_addr", 16'(io_addr), 16'(a));
      @(posedge clk);
      #1;
      if (op == AOG_OP_IO_BIT_SET_OP || op == AOG_OP_IO_BIT_CLEAR_OP) begin
         chk("io_we", 16'(io_we), 16'(a <= 6'h1f));
         if (a <= 6'h1f) chk("io_wdata", 16'(io_wdata), {8'h00, w});
      end else chk("skip", 16'(skip), {8'h00, w});
      wait_ready;
   endtask : bit_op
   task automatic t_bits;
      bit_op(AOG_OP_IO_BIT_SET_OP, 6'h1f, 3'h3, 8'h81, 8'h89);
      bit_op(AOG_OP_IO_BIT_CLEAR_OP, 6'h00, 3'h7, 8'h81, 8'h01);
      bit_op(AOG_OP_IO_BIT_SET_OP, 6'h20, 3'h0, 8'h00, 8'h00);
      bit_op(AOG_OP_SKIP_IF_BIT_SET, 6'h1f, 3'h7, 8'h80, 8'h01);
      bit_op(AOG_OP_SKIP_IF_BIT_SET, 6'h05, 3'h7, 8'h7f, 8'h00);
      bit_op(AOG_OP_SKIP_IF_BIT_CLEAR, 6'h05, 3'h0, 8'h80, 8'h01);
   endtask : t_bits
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      r = '0;
      alu_result = 8'h00;
      sram_rdata = 8'h00;
      io_rdata = 8'h00;
      code_rdata = 16'h0000;
      bad_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("ready_rst", 16'(req_ready), 16'h0001);
      chk("pc_rst", 16'(pc), 16'h0000);
      chk("fetch_rst", 16'(fetch_addr), 16'h0001);
      t_direct;
      t_pair;
      t_ptr;
      t_code;
      t_flow;
      t_bits;
      tally_and_finish;
   end
   // whole run is about 135 cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      tally_and_finish;
   end
endmodule : tb_top
